/* File: backup_pkg.sv */
// constants, field layouts and carriers for the backup monitor register bank
// assumes a single 50 MHz clock and a two-wire serial host port
// Operation
// - peak-limit field bits 5:4 picks boost peak current, resets to 11
// - storage-good threshold bits 3:0, 80 to 95 percent, resets to 1111
// - five-bit warning level, reset all ones, compared with temperature result high bits
// - source bit 4 enables storage voltage conversion, resets to 0
// - source bit 2 enables temperature sensor conversion, resets to 0
// - source bit 1 enables input current conversion, resets to 0
// - source bit 0 enables input voltage conversion, resets to 0
// - input voltage result: high byte 0x0a, low two bits 0x0b, reset zero
// - input current result: high byte 0x0c, low two bits 0x0d
// - temperature result: high byte 0x0e, low two bits 0x0f
// - first storage result: high byte 0x12, low two bits 0x13
// - second storage result: high byte 0x14, low two bits 0x15
// - test timer 16 bits, low byte 0x16, high byte 0x17, reset zero
// - recovery bit 1 turns storage-fed regulator on, reset off
// - recovery bit 0 selects stay-in-buck or leave-buck-and-recharge policy
// - conversion done sets status bit; interrupt unless its mask is set
// - temperature warning sets status bit; interrupt only when mask bit 0 clear
package backup_pkg;
	localparam logic [6:0] DEV_ADDR = 7'h2a; // arbitrary bus address
	localparam logic [7:0] OFS_STATUS = 8'h02;
	localparam logic [7:0] OFS_MASK = 8'h04;
	localparam logic [7:0] OFS_THRESH = 8'h06;
	localparam logic [7:0] OFS_WARN = 8'h07;
	localparam logic [7:0] OFS_SRC = 8'h09;
	localparam logic [7:0] OFS_VIN_H = 8'h0a;
	localparam logic [7:0] OFS_VIN_L = 8'h0b;
	localparam logic [7:0] OFS_IIN_H = 8'h0c;
	localparam logic [7:0] OFS_IIN_L = 8'h0d;
	localparam logic [7:0] OFS_TMP_H = 8'h0e;
	localparam logic [7:0] OFS_TMP_L = 8'h0f;
	localparam logic [7:0] OFS_ST1_H = 8'h12;
	localparam logic [7:0] OFS_ST1_L = 8'h13;
	localparam logic [7:0] OFS_ST2_H = 8'h14;
	localparam logic [7:0] OFS_ST2_L = 8'h15;
	localparam logic [7:0] OFS_TMR_L = 8'h16;
	localparam logic [7:0] OFS_TMR_H = 8'h17;
	localparam logic [7:0] OFS_RECOV = 8'h1b;
	localparam int BIT_CONV_DONE = 6;
	localparam int BIT_TEMP_WARN = 0;
	localparam int BIT_SRC_STORAGE_NODE = 4;
	localparam int BIT_SRC_TEMP = 2;
	localparam int BIT_SRC_IIN = 1;
	localparam int BIT_SRC_VIN = 0;
	localparam int BIT_REG_ON = 1;
	localparam int BIT_RECOVER = 0;
	localparam logic [1:0] RST_PEAK = 2'h3;
	localparam logic [3:0] RST_GOOD = 4'hf;
	localparam logic [4:0] RST_WARN = 5'h1f;
	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_write_s;
	typedef struct packed {
		logic [9:0] inputVoltage;
		logic [9:0] inputCurrent;
		logic [9:0] tempVoltage;
		logic [9:0] storage1;
		logic [9:0] storage2;
	} conv_sample_s;
	typedef struct packed {
		logic [1:0] boostPeakLimitSel;
		logic [3:0] storageGoodMonitor;
		logic storageSel;
		logic tempSel;
		logic currentSel;
		logic inputSel;
		logic storageRegulatorOn;
		logic recoverMode;
	} ctrl_s;
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_DEV = 4'h1,
		S_ACK_DEV = 4'h3,
		S_PTR = 4'h2,
		S_ACK_PTR = 4'h6,
		S_WRITE = 4'h7,
		S_ACK_WR = 4'h5,
		S_READ = 4'h4,
		S_READ_ACK = 4'hc
	} port_state_e;
endpackage : backup_pkg

/* File: serial_reg_port.sv */
// two-wire serial slave: pointer byte, writes and reads with auto-increment
// assumes scl and sda already synchronised to mclk
module serial_reg_port (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// synchronised line levels
	input wire logic sclS,
	input wire logic sdaS,
	output logic sdaOe,
	// register side
	output backup_pkg::reg_write_s wr,
	output logic [7:0] ptr,
	input wire logic [7:0] rdData
);
	backup_pkg::port_state_e state;
	logic sclPrev;
	logic sdaPrev;
	logic [7:0] shift;
	logic [7:0] tx;
	logic [2:0] cnt;
	logic byteDone;
	logic rw;
	logic nack;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;

	assign sclRise = sclS & ~sclPrev;
	assign sclFall = ~sclS & sclPrev;
	assign startSeen = sclS & sclPrev & sdaPrev & ~sdaS;
	assign stopSeen = sclS & sclPrev & ~sdaPrev & sdaS;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end else begin
			sclPrev <= sclS;
			sdaPrev <= sdaS;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state <= backup_pkg::S_IDLE;
			shift <= 8'h00;
			tx <= 8'h00;
			cnt <= 3'h0;
			byteDone <= 1'b0;
			rw <= 1'b0;
			nack <= 1'b0;
			sdaOe <= 1'b0;
			ptr <= 8'h00;
			wr <= '0;
		end else begin
			wr.en <= 1'b0;
			if (startSeen) begin
				state <= backup_pkg::S_DEV;
				cnt <= 3'h0;
				byteDone <= 1'b0;
				sdaOe <= 1'b0;
			end else if (stopSeen) begin
				state <= backup_pkg::S_IDLE;
				sdaOe <= 1'b0;
			end else if (sclRise) begin
				case (state)
					backup_pkg::S_DEV, backup_pkg::S_PTR, backup_pkg::S_WRITE: begin
						shift <= {shift[6:0], sdaS};
						cnt <= cnt + 3'h1;
						byteDone <= (cnt == 3'h7);
					end
					backup_pkg::S_READ: begin
						cnt <= cnt + 3'h1;
						byteDone <= (cnt == 3'h7);
					end
					backup_pkg::S_READ_ACK: nack <= sdaS;
					default: ;
				endcase
			end else if (sclFall) begin
				case (state)
					backup_pkg::S_DEV: if (byteDone) begin
						byteDone <= 1'b0;
						if (shift[7:1] == backup_pkg::DEV_ADDR) begin
							rw <= shift[0];
							sdaOe <= 1'b1;
							state <= backup_pkg::S_ACK_DEV;
						end else begin
							state <= backup_pkg::S_IDLE;
						end
					end
					backup_pkg::S_ACK_DEV: begin
						cnt <= 3'h0;
						if (rw) begin
							tx <= rdData;
							sdaOe <= ~rdData[7];
							state <= backup_pkg::S_READ;
						end else begin
							sdaOe <= 1'b0;
							state <= backup_pkg::S_PTR;
						end
					end
					backup_pkg::S_PTR: if (byteDone) begin
						byteDone <= 1'b0;
						ptr <= shift;
						sdaOe <= 1'b1;
						state <= backup_pkg::S_ACK_PTR;
					end
					backup_pkg::S_ACK_PTR, backup_pkg::S_ACK_WR: begin
						sdaOe <= 1'b0;
						state <= backup_pkg::S_WRITE;
					end
					backup_pkg::S_WRITE: if (byteDone) begin
						byteDone <= 1'b0;
						wr.en <= 1'b1;
						wr.addr <= ptr;
						wr.data <= shift;
						ptr <= ptr + 8'h01;
						sdaOe <= 1'b1;
						state <= backup_pkg::S_ACK_WR;
					end
					backup_pkg::S_READ: begin
						if (byteDone) begin
							byteDone <= 1'b0;
							sdaOe <= 1'b0;
							ptr <= ptr + 8'h01;
							state <= backup_pkg::S_READ_ACK;
						end else begin
							tx <= {tx[6:0], 1'b0};
							sdaOe <= ~tx[6];
						end
					end
					backup_pkg::S_READ_ACK: begin
						if (nack) begin
							state <= backup_pkg::S_IDLE;
						end else begin
							tx <= rdData;
							sdaOe <= ~rdData[7];
							cnt <= 3'h0;
							state <= backup_pkg::S_READ;
						end
					end
					default: state <= backup_pkg::S_IDLE;
				endcase
			end
		end
	end
endmodule : serial_reg_port

/* File: backup_monitor_adc_regs.sv */
// register bank for thresholds, conversion sources, results and recovery control
// assumes converter strobes come from mclk logic, serial pins are asynchronous
module backup_monitor_adc_regs (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// two-wire serial pins
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// converter and capacitor test
	input wire logic convDone,
	input wire backup_pkg::conv_sample_s sample,
	input wire logic capTestDone,
	input wire logic [15:0] capTestTime,
	// control and status outputs
	output backup_pkg::ctrl_s ctrl,
	output logic tempWarning,
	output logic intN
);
	logic [1:0] sclSync;
	logic [1:0] sdaSync;
	backup_pkg::reg_write_s wr;
	logic [7:0] ptr;
	logic [7:0] rdData;
	logic portSdaOe;
	logic [4:0] warnLevel;
	logic [9:0] vinRes;
	logic [9:0] iinRes;
	logic [9:0] tmpRes;
	logic [9:0] st1Res;
	logic [9:0] st2Res;
	logic [15:0] timerRes;
	logic statusDone;
	logic statusWarn;
	logic maskDone;
	logic maskWarn;
	logic warnHit;
	logic clrDone;
	logic clrWarn;

	// pin synchronisers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sclSync <= 2'h3;
			sdaSync <= 2'h3;
		end else begin
			sclSync <= {sclSync[0], sclIn};
			sdaSync <= {sdaSync[0], sdaIn};
		end
	end

	serial_reg_port port (
		.mclk(mclk),
		.rstn(rstn),
		.sclS(sclSync[1]),
		.sdaS(sdaSync[1]),
		.sdaOe(portSdaOe),
		.wr(wr),
		.ptr(ptr),
		.rdData(rdData)
	);

	// open-drain data line
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sdaOut <= 1'b0;
			sdaOe <= 1'b0;
		end else begin
			sdaOut <= 1'b0;
			sdaOe <= portSdaOe;
		end
	end

	// writable control fields
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctrl.boostPeakLimitSel <= backup_pkg::RST_PEAK;
			ctrl.storageGoodMonitor <= backup_pkg::RST_GOOD;
			warnLevel <= backup_pkg::RST_WARN;
			ctrl.storageSel <= 1'b0;
			ctrl.tempSel <= 1'b0;
			ctrl.currentSel <= 1'b0;
			ctrl.inputSel <= 1'b0;
			ctrl.storageRegulatorOn <= 1'b0;
			ctrl.recoverMode <= 1'b0;
			maskDone <= 1'b0;
			maskWarn <= 1'b0;
		end else if (wr.en) begin
			case (wr.addr)
				backup_pkg::OFS_THRESH: begin
					ctrl.boostPeakLimitSel <= wr.data[5:4];
					ctrl.storageGoodMonitor <= wr.data[3:0];
				end
				backup_pkg::OFS_WARN: warnLevel <= wr.data[4:0];
				backup_pkg::OFS_SRC: begin
					ctrl.storageSel <= wr.data[backup_pkg::BIT_SRC_STORAGE_NODE];
					ctrl.tempSel <= wr.data[backup_pkg::BIT_SRC_TEMP];
					ctrl.currentSel <= wr.data[backup_pkg::BIT_SRC_IIN];
					ctrl.inputSel <= wr.data[backup_pkg::BIT_SRC_VIN];
				end
				backup_pkg::OFS_RECOV: begin
					ctrl.storageRegulatorOn <= wr.data[backup_pkg::BIT_REG_ON];
					ctrl.recoverMode <= wr.data[backup_pkg::BIT_RECOVER];
				end
				backup_pkg::OFS_MASK: begin
					maskDone <= wr.data[backup_pkg::BIT_CONV_DONE];
					maskWarn <= wr.data[backup_pkg::BIT_TEMP_WARN];
				end
				default: ;
			endcase
		end
	end

	// results: whole pairs replaced at once, host writes never reach them
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			vinRes <= 10'h000;
			iinRes <= 10'h000;
			tmpRes <= 10'h000;
			st1Res <= 10'h000;
			st2Res <= 10'h000;
		end else if (convDone) begin
			if (ctrl.inputSel) begin
				vinRes <= sample.inputVoltage;
			end
			if (ctrl.currentSel) begin
				iinRes <= sample.inputCurrent;
			end
			if (ctrl.tempSel) begin
				tmpRes <= sample.tempVoltage;
			end
			if (ctrl.storageSel) begin
				st1Res <= sample.storage1;
				st2Res <= sample.storage2;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			timerRes <= 16'h0000;
		end else if (capTestDone) begin
			timerRes <= capTestTime;
		end
	end

	// warning compare on the fresh temperature sample
	assign warnHit = convDone & ctrl.tempSel & (sample.tempVoltage[9:5] > warnLevel);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tempWarning <= 1'b0;
		end else if (convDone & ctrl.tempSel) begin
			tempWarning <= warnHit;
		end
	end

	// sticky status, write one clears, a new event wins over the clear
	assign clrDone = wr.en & (wr.addr == backup_pkg::OFS_STATUS) & wr.data[backup_pkg::BIT_CONV_DONE];
	assign clrWarn = wr.en & (wr.addr == backup_pkg::OFS_STATUS) & wr.data[backup_pkg::BIT_TEMP_WARN];

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			statusDone <= 1'b0;
			statusWarn <= 1'b0;
		end else begin
			statusDone <= convDone | (statusDone & ~clrDone);
			statusWarn <= warnHit | (statusWarn & ~clrWarn);
		end
	end

	// interrupt line, low while any unmasked status bit stands
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			intN <= 1'b1;
		end else begin
			intN <= ~((statusDone & ~maskDone) | (statusWarn & ~maskWarn));
		end
	end

	// read-back mux, reserved bits and unmapped offsets read zero
	always_comb begin
		rdData = 8'h00;
		case (ptr)
			backup_pkg::OFS_STATUS: begin
				rdData[backup_pkg::BIT_CONV_DONE] = statusDone;
				rdData[backup_pkg::BIT_TEMP_WARN] = statusWarn;
			end
			backup_pkg::OFS_MASK: begin
				rdData[backup_pkg::BIT_CONV_DONE] = maskDone;
				rdData[backup_pkg::BIT_TEMP_WARN] = maskWarn;
			end
			backup_pkg::OFS_THRESH: rdData = {2'h0, ctrl.boostPeakLimitSel, ctrl.storageGoodMonitor};
			backup_pkg::OFS_WARN: rdData = {3'h0, warnLevel};
			backup_pkg::OFS_SRC: begin
				rdData[backup_pkg::BIT_SRC_STORAGE_NODE] = ctrl.storageSel;
				rdData[backup_pkg::BIT_SRC_TEMP] = ctrl.tempSel;
				rdData[backup_pkg::BIT_SRC_IIN] = ctrl.currentSel;
				rdData[backup_pkg::BIT_SRC_VIN] = ctrl.inputSel;
			end
			backup_pkg::OFS_VIN_H: rdData = vinRes[9:2];
			backup_pkg::OFS_VIN_L: rdData = {6'h00, vinRes[1:0]};
			backup_pkg::OFS_IIN_H: rdData = iinRes[9:2];
			backup_pkg::OFS_IIN_L: rdData = {6'h00, iinRes[1:0]};
			backup_pkg::OFS_TMP_H: rdData = tmpRes[9:2];
			backup_pkg::OFS_TMP_L: rdData = {6'h00, tmpRes[1:0]};
			backup_pkg::OFS_ST1_H: rdData = st1Res[9:2];
			backup_pkg::OFS_ST1_L: rdData = {6'h00, st1Res[1:0]};
			backup_pkg::OFS_ST2_H: rdData = st2Res[9:2];
			backup_pkg::OFS_ST2_L: rdData = {6'h00, st2Res[1:0]};
			backup_pkg::OFS_TMR_L: rdData = timerRes[7:0];
			backup_pkg::OFS_TMR_H: rdData = timerRes[15:8];
			backup_pkg::OFS_RECOV: begin
				rdData[backup_pkg::BIT_REG_ON] = ctrl.storageRegulatorOn;
				rdData[backup_pkg::BIT_RECOVER] = ctrl.recoverMode;
			end
			default: rdData = 8'h00;
		endcase
	end
endmodule : backup_monitor_adc_regs

/* File: host_model.sv */
// two-wire bus host model: start, stop, byte transfers, register write and paired read
// assumes sda has a pull-up outside, the model only pulls it low
module host_model (
	// clock
	input wire logic mclk,
	// bus lines
	input wire logic sdaLine,
	output logic scl,
	output logic sdaPull
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		scl = 1'b1;
		sdaPull = 1'b0;
	end
	// half bus period, above the minimum the device needs
	task automatic half();
		repeat (10) @(posedge mclk);
	endtask : half
	// data moves one edge after the scl fall, never together with it
	task automatic setSda(input logic pull);
		@(posedge mclk);
		sdaPull <= pull;
	endtask : setSda
	task automatic startBit();
		setSda(1'b0);
		half();
		scl <= 1'b1;
		half();
		setSda(1'b1);
		half();
		scl <= 1'b0;
	endtask : startBit
	task automatic stopBit();
		setSda(1'b1);
		half();
		scl <= 1'b1;
		half();
		setSda(1'b0);
		half();
	endtask : stopBit
	task automatic sendByte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			setSda(~b[i]);
			half();
			scl <= 1'b1;
			half();
			scl <= 1'b0;
		end
		setSda(1'b0);
		half();
		scl <= 1'b1;
		half();
		ack = ~sdaLine;
		scl <= 1'b0;
	endtask : sendByte
	task automatic recvByte(input logic last, output logic [7:0] d);
		setSda(1'b0);
		for (int i = 7; i >= 0; i--) begin
			half();
			scl <= 1'b1;
			half();
			d[i] = sdaLine;
			scl <= 1'b0;
		end
		setSda(~last);
		half();
		scl <= 1'b1;
		half();
		scl <= 1'b0;
	endtask : recvByte
	task automatic writeReg(input logic [6:0] dev, input logic [7:0] ofs, dat, output logic ok);
		logic a0, a1, a2;
		startBit();
		sendByte({dev, 1'b0}, a0);
		sendByte(ofs, a1);
		sendByte(dat, a2);
		stopBit();
		ok = a0 & a1 & a2;
	endtask : writeReg
	// reads two bytes from ofs onward through a repeated start
	task automatic readTwo(input logic [7:0] ofs, output logic [7:0] d0, d1);
		logic a;
		startBit();
		sendByte({backup_pkg::DEV_ADDR, 1'b0}, a);
		sendByte(ofs, a);
		startBit();
		sendByte({backup_pkg::DEV_ADDR, 1'b1}, a);
		recvByte(1'b0, d0);
		recvByte(1'b1, d1);
		stopBit();
	endtask : readTwo
endmodule : host_model

/* File: backup_regs_checker_sva.sv */
// port checks for the backup monitor register bank
// assumes one mclk domain with asynchronous active-low rstn
module backup_regs_checker (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// serial pins
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	// converter and test timer
	input wire logic convDone,
	input wire backup_pkg::conv_sample_s sample,
	input wire logic capTestDone,
	input wire logic [15:0] capTestTime,
	// outputs
	input wire backup_pkg::ctrl_s ctrl,
	input wire logic tempWarning,
	input wire logic intN
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	reset_peak_a: assert property ($rose(rstn) |-> ctrl.boostPeakLimitSel == 2'h3
		&& ctrl.storageGoodMonitor == 4'hf) else $error("control thresholds not at reset");
	reset_src_a: assert property ($rose(rstn) |-> !ctrl.storageSel && !ctrl.tempSel
		&& !ctrl.currentSel && !ctrl.inputSel) else $error("source selects not cleared by reset");
	reset_recov_a: assert property ($rose(rstn) |-> ctrl.storageRegulatorOn == 1'b0
		&& ctrl.recoverMode == 1'b0) else $error("recovery control not cleared by reset");
	reset_flags_a: assert property ($rose(rstn) |-> !tempWarning && intN)
		else $error("warning or interrupt active after reset");
	ctrl_write_a: assert property (!$stable(ctrl) |-> !sclIn && !$past(sclIn))
		else $error("control changed outside a bus write");
	warn_hold_a: assert property (!(convDone && ctrl.tempSel) |=> $stable(tempWarning))
		else $error("warning moved without a temperature conversion");
	warn_low_a: assert property (convDone && ctrl.tempSel && sample.tempVoltage[9:5] == 5'h00
		|=> !tempWarning) else $error("warning set by a zero temperature result");
	int_cause_a: assert property ($fell(intN) |-> $past(convDone, 2) || !sclIn)
		else $error("interrupt without a conversion event");
endmodule : backup_regs_checker

bind backup_monitor_adc_regs backup_regs_checker checker_inst (.mclk(mclk), .rstn(rstn),
	.sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .convDone(convDone),
	.sample(sample), .capTestDone(capTestDone), .capTestTime(capTestTime), .ctrl(ctrl),
	.tempWarning(tempWarning), .intN(intN));

/* File: test_backup_monitor_adc_regs.sv */
// self-checking bench for the backup monitor register bank
// assumes host_model on the bus and a pull-up on sda
module test_backup_monitor_adc_regs;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [7:0] ofs;
		logic [7:0] wdata;
		logic [7:0] rexp;
	} row_s;
	logic mclk, rstn, convDone, capTestDone, sdaOut, sdaOe, tempWarning, intN, ok, expWarn;
	logic [15:0] capTestTime;
	logic [7:0] rd0, rd1;
	logic [9:0] v [5];
	logic [9:0] expv [5];
	backup_pkg::conv_sample_s sample;
	backup_pkg::ctrl_s ctrl;
	wire scl, sdaPull;
	wire sdaLine = ~(sdaOe | sdaPull);
	int failCount, totalChecks;
	row_s rows [6] = '{'{8'h06, 8'h25, 8'h25}, '{8'h07, 8'h0a, 8'h0a}, '{8'h09, 8'h17, 8'h17},
		'{8'h1b, 8'h03, 8'h03}, '{8'h0a, 8'hff, 8'h00}, '{8'h30, 8'h55, 8'h00}};
	logic [7:0] ofsH [6] = '{8'h0a, 8'h0c, 8'h0e, 8'h12, 8'h14, 8'h16};
	logic [7:0] srcs [5] = '{8'h17, 8'h01, 8'h02, 8'h04, 8'h14};
	backup_monitor_adc_regs DUT (.mclk(mclk), .rstn(rstn), .sclIn(scl), .sdaIn(sdaLine),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .convDone(convDone), .sample(sample),
		.capTestDone(capTestDone), .capTestTime(capTestTime), .ctrl(ctrl),
		.tempWarning(tempWarning), .intN(intN));
	host_model host (.mclk(mclk), .sdaLine(sdaLine), .scl(scl), .sdaPull(sdaPull));
	always #10 mclk = ~mclk;
	task automatic check(input string name, input logic [15:0] exp, got);
		totalChecks++;
		if (got !== exp) begin
			failCount++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic reportAndStop();
		$display("checks %0d mismatches %0d", totalChecks, failCount);
		if (failCount == 0 && totalChecks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : reportAndStop
	task automatic resetChecks();
		check("ctrl", 16'h0fc0, ctrl);
		check("sdaOut", 16'h0, sdaOut);
		host.readTwo(8'h06, rd0, rd1);
		check("thresh", 16'h3f, rd0);
		check("warn", 16'h1f, rd1);
		host.readTwo(8'h1b, rd0, rd1);
		check("recov", 16'h00, rd0);
	endtask : resetChecks
	initial begin
		repeat (95000) @(posedge mclk);
		failCount++;
		reportAndStop();
	end
	initial begin
		mclk = 1'b0;
		rstn = 1'b0;
		convDone = 1'b0;
		capTestDone = 1'b0;
		capTestTime = 16'h0000;
		sample = '0;
		expWarn = 1'b0;
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		resetChecks();
		for (int i = 0; i < 6; i++) begin
			host.readTwo(ofsH[i], rd0, rd1);
			check("result high", 16'h00, rd0);
			check("result low", 16'h00, rd1);
			expv[i % 5] = 10'h000;
		end
		for (int r = 0; r < 6; r++) begin
			host.writeReg(backup_pkg::DEV_ADDR, rows[r].ofs, rows[r].wdata, ok);
			check("ack", 16'h1, ok);
			host.readTwo(rows[r].ofs, rd0, rd1);
			check("readback", rows[r].rexp, rd0);
		end
		check("ctrl", 16'h097f, ctrl);
		for (int k = 0; k < 5; k++) begin
			host.writeReg(backup_pkg::DEV_ADDR, backup_pkg::OFS_SRC, srcs[k], ok);
			for (int i = 0; i < 5; i++) v[i] = 10'h3ff - 10'(k * 61 + i * 17);
			if (k == 3) v[2] = 10'h15f;
			if (k == 4) v[2] = 10'h01f;
			@(posedge mclk);
			sample <= {v[0], v[1], v[2], v[3], v[4]};
			convDone <= 1'b1;
			@(posedge mclk);
			convDone <= 1'b0;
			if (srcs[k][0]) expv[0] = v[0];
			if (srcs[k][1]) expv[1] = v[1];
			if (srcs[k][2]) begin
				expv[2] = v[2];
				expWarn = v[2][9:5] > 5'h0a;
			end
			if (srcs[k][4]) begin
				expv[3] = v[3];
				expv[4] = v[4];
			end
			repeat (3) @(posedge mclk);
			check("tempWarning", expWarn, tempWarning);
			check("intN", 16'h0, intN);
			for (int i = 0; i < 5; i++) begin
				host.readTwo(ofsH[i], rd0, rd1);
				check("high byte", expv[i][9:2], rd0);
				check("low bits", expv[i][1:0], rd1);
			end
		end
		host.writeReg(backup_pkg::DEV_ADDR, backup_pkg::OFS_RECOV, 8'h02, ok);
		check("regulator on", 16'h1, ctrl.storageRegulatorOn);
		@(posedge mclk);
		capTestTime <= 16'ha5c3;
		capTestDone <= 1'b1;
		@(posedge mclk);
		capTestDone <= 1'b0;
		host.writeReg(backup_pkg::DEV_ADDR, backup_pkg::OFS_RECOV, 8'h01, ok);
		check("regulator off", 16'h2, {ctrl.recoverMode, ctrl.storageRegulatorOn});
		host.readTwo(backup_pkg::OFS_TMR_L, rd0, rd1);
		check("timer low", 16'hc3, rd0);
		check("timer high", 16'ha5, rd1);
		host.writeReg(backup_pkg::DEV_ADDR, backup_pkg::OFS_ST1_H, 8'h00, ok);
		host.writeReg(backup_pkg::DEV_ADDR, backup_pkg::OFS_TMR_L, 8'h00, ok);
		host.readTwo(backup_pkg::OFS_ST1_H, rd0, rd1);
		check("storage kept", expv[3][9:2], rd0);
		host.readTwo(backup_pkg::OFS_TMR_L, rd0, rd1);
		check("timer kept", 16'hc3, rd0);
		host.writeReg(7'h2b, backup_pkg::OFS_THRESH, 8'h00, ok);
		check("foreign ack", 16'h0, ok);
		host.readTwo(backup_pkg::OFS_THRESH, rd0, rd1);
		check("thresh kept", 16'h25, rd0);
		host.writeReg(backup_pkg::DEV_ADDR, backup_pkg::OFS_MASK, 8'h40, ok);
		check("intN warn unmasked", 16'h0, intN);
		host.writeReg(backup_pkg::DEV_ADDR, backup_pkg::OFS_MASK, 8'h41, ok);
		check("intN masked", 16'h1, intN);
		host.readTwo(backup_pkg::OFS_STATUS, rd0, rd1);
		check("status masked", 16'h41, rd0);
		host.writeReg(backup_pkg::DEV_ADDR, backup_pkg::OFS_STATUS, 8'h41, ok);
		host.writeReg(backup_pkg::DEV_ADDR, backup_pkg::OFS_MASK, 8'h00, ok);
		host.readTwo(backup_pkg::OFS_STATUS, rd0, rd1);
		check("status cleared", 16'h00, rd0);
		check("intN cleared", 16'h1, intN);
		@(posedge mclk);
		sample <= '1;
		convDone <= 1'b1;
		@(posedge mclk);
		convDone <= 1'b0;
		repeat (3) @(posedge mclk);
		check("warn before reset", 16'h1, tempWarning);
		check("intN before reset", 16'h0, intN);
		@(posedge mclk);
		rstn <= 1'b0;
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		check("flags", 16'h1, {tempWarning, intN});
		resetChecks();
		reportAndStop();
	end
endmodule : test_backup_monitor_adc_regs
